// >>> hdl/core_feature_config_regs.vh
`ifndef CORE_FEATURE_CONFIG_REGS_VH
`define CORE_FEATURE_CONFIG_REGS_VH

// ********************************************
// access address
// ********************************************
`define CFC_REG_NUM          5'h10
`define CFC_REG_SEL          3'h3

// ********************************************
// bit positions
// ********************************************
`define CFC_FOURTH_CFG_BIT   31
`define CFC_UNIMPL_HI_MSB    30
`define CFC_UNIMPL_HI_LSB    23
`define CFC_PLW_MSB          22
`define CFC_PLW_LSB          21
`define CFC_CAR_MSB          20
`define CFC_CAR_MID_BIT      19
`define CFC_CAR_LSB          18
`define CFC_MCU_BIT          17
`define CFC_EXC_SET_BIT      16
`define CFC_BOOT_SET_MSB     15
`define CFC_BOOT_SET_LSB     14
`define CFC_ULR_BIT          13
`define CFC_RXI_BIT          12
`define CFC_DSP2_BIT         11
`define CFC_DSP_BIT          10
`define CFC_UNIMPL_9_BIT     9
`define CFC_TRACE_BIT        8
`define CFC_UNIMPL_7_BIT     7
`define CFC_EIC_BIT          6
`define CFC_VECTORED_IRQ_FLAG_BIT         5
`define CFC_SP_BIT           4
`define CFC_CDM_BIT          3
`define CFC_UNIMPL_LO_MSB    2
`define CFC_UNIMPL_LO_LSB    1
`define CFC_TL_BIT           0

// ********************************************
// field values
// ********************************************
`define CFC_PLW_VAL          2'h1
`define CFC_CAR_VAL          3'h0
`define CFC_BOOT_COMPACT     2'h3
`define CFC_BOOT_FULL        2'h2
`define CFC_BOOT_CFG_BIT     6
`define CFC_WORD_BITS        32

`endif

// >>> hdl/core_feature_config_register.v
// Notes on behaviour
// - bit 31 reads one always
// - bits 30 to 23 read zero
// - bits 22:21 read 01, eight-bit levels
// - bits 20:18 read 000, release one
// - bit 17 reads one, extension present
// - bit 16 exception-entry set, read/write
// - bits 15:14 report reset instruction set
// - boot config bit 6 loads both fields
// - bit 13 reads one, user-local present
// - bit 12 reads one, inhibit bits present
// - bits 11 and 10 read one
// - bit 8 reads one, trace present
// - bits 9, 7, 2:1 read zero
// - bit 6 reads one, external controller
// - bit 5 reads one, vectored interrupts
// - bit 4 reads zero, 4 KB pages
// - bit 3 reads one, device map
// - bit 0 reads zero, legacy trace
// - reached as register 16 select 3
`timescale 1ns/1ps
`include "core_feature_config_regs.vh"

module core_feature_config_register (
  input  wire        clk,
  input  wire        reset,
  input  wire [31:0] device_config_word0,
  input  wire        cp0_read,
  input  wire        cp0_write,
  input  wire [4:0]  cp0_reg_num,
  input  wire [2:0]  cp0_reg_sel,
  input  wire [31:0] cp0_wdata,
  output reg  [31:0] cp0_rdata,
  output wire        cp0_hit,
  output wire        exception_entry_set_bit
);

  // ********************************************
  // kinds of register bit
  // ********************************************
  localparam [2:0] KIND_ZERO   = 3'h0;
  localparam [2:0] KIND_ONE    = 3'h1;
  localparam [2:0] KIND_PLW    = 3'h2;
  localparam [2:0] KIND_CAR    = 3'h3;
  localparam [2:0] KIND_EXC    = 3'h4;
  localparam [2:0] KIND_BOOT   = 3'h5;
  localparam [2:0] KIND_UNUSED = 3'h6;

  // ********************************************
  // field words
  // ********************************************
  localparam [31:0] ZERO_WORD = 32'h00000000;
  localparam [31:0] PLW_WORD  = {30'h0, `CFC_PLW_VAL} << `CFC_PLW_LSB;
  localparam [31:0] CAR_WORD  = {29'h0, `CFC_CAR_VAL} << `CFC_CAR_LSB;

  // ********************************************
  // address match
  // ********************************************
  function addr_match;
    input [4:0] num;
    input [2:0] sel;
    begin
      addr_match = (num == `CFC_REG_NUM) && (sel == `CFC_REG_SEL);
    end
  endfunction

  // ********************************************
  // reset instruction set code
  // ********************************************
  function [1:0] boot_field_code;
    input boot_compact;
    begin
      case (boot_compact)
        1'b1: begin
          boot_field_code = `CFC_BOOT_COMPACT;
        end
        1'b0: begin
          boot_field_code = `CFC_BOOT_FULL;
        end
        default: begin
          boot_field_code = `CFC_BOOT_FULL;
        end
      endcase
    end
  endfunction

  // ********************************************
  // kind of each bit position
  // ********************************************
  function [2:0] bit_kind;
    input [4:0] pos;
    begin
      case (pos)
        // upper byte and bit 23
        `CFC_FOURTH_CFG_BIT: begin
          bit_kind = KIND_ONE;
        end
        `CFC_UNIMPL_HI_MSB: begin
          bit_kind = KIND_UNUSED;
        end
        `CFC_UNIMPL_HI_LSB: begin
          bit_kind = KIND_UNUSED;
        end

        // second byte
        `CFC_PLW_MSB: begin
          bit_kind = KIND_PLW;
        end
        `CFC_PLW_LSB: begin
          bit_kind = KIND_PLW;
        end
        `CFC_CAR_MSB: begin
          bit_kind = KIND_CAR;
        end
        `CFC_CAR_MID_BIT: begin
          bit_kind = KIND_CAR;
        end
        `CFC_CAR_LSB: begin
          bit_kind = KIND_CAR;
        end
        `CFC_MCU_BIT: begin
          bit_kind = KIND_ONE;
        end
        `CFC_EXC_SET_BIT: begin
          bit_kind = KIND_EXC;
        end

        // third byte
        `CFC_BOOT_SET_MSB: begin
          bit_kind = KIND_BOOT;
        end
        `CFC_BOOT_SET_LSB: begin
          bit_kind = KIND_BOOT;
        end
        `CFC_ULR_BIT: begin
          bit_kind = KIND_ONE;
        end
        `CFC_RXI_BIT: begin
          bit_kind = KIND_ONE;
        end
        `CFC_DSP2_BIT: begin
          bit_kind = KIND_ONE;
        end
        `CFC_DSP_BIT: begin
          bit_kind = KIND_ONE;
        end
        `CFC_UNIMPL_9_BIT: begin
          bit_kind = KIND_UNUSED;
        end
        `CFC_TRACE_BIT: begin
          bit_kind = KIND_ONE;
        end

        // lower byte
        `CFC_UNIMPL_7_BIT: begin
          bit_kind = KIND_UNUSED;
        end
        `CFC_EIC_BIT: begin
          bit_kind = KIND_ONE;
        end
        `CFC_VECTORED_IRQ_FLAG_BIT: begin
          bit_kind = KIND_ONE;
        end
        `CFC_SP_BIT: begin
          bit_kind = KIND_ZERO;
        end
        `CFC_CDM_BIT: begin
          bit_kind = KIND_ONE;
        end
        `CFC_UNIMPL_LO_MSB: begin
          bit_kind = KIND_UNUSED;
        end
        `CFC_UNIMPL_LO_LSB: begin
          bit_kind = KIND_UNUSED;
        end
        `CFC_TL_BIT: begin
          bit_kind = KIND_ZERO;
        end
        // rest of the unimplemented upper bits
        default: begin
          bit_kind = KIND_UNUSED;
        end
      endcase
    end
  endfunction

  // ********************************************
  // value of one bit
  // ********************************************
  function bit_value;
    input [2:0]  kind;
    input [4:0]  pos;
    input        boot_compact;
    input        exc_set;
    reg   [31:0] boot_word;
    begin
      boot_word = {30'h0, boot_field_code(boot_compact)} << `CFC_BOOT_SET_LSB;
      case (kind)
        // fixed levels
        KIND_ZERO: begin
          bit_value = 1'b0;
        end
        KIND_UNUSED: begin
          bit_value = 1'b0;
        end
        KIND_ONE: begin
          bit_value = 1'b1;
        end

        // multi-bit fixed fields
        KIND_PLW: begin
          bit_value = PLW_WORD[pos];
        end
        KIND_CAR: begin
          bit_value = CAR_WORD[pos];
        end

        // bits set by boot choice or software
        KIND_EXC: begin
          bit_value = exc_set;
        end
        KIND_BOOT: begin
          bit_value = boot_word[pos];
        end
        default: begin
          bit_value = 1'b0;
        end
      endcase
    end
  endfunction

  // ********************************************
  // whole register image
  // ********************************************
  function [31:0] feature_image;
    input   boot_compact;
    input   exc_set;
    integer pos;
    begin
      feature_image = ZERO_WORD;
      for (pos = 0; pos < `CFC_WORD_BITS; pos = pos + 1) begin
        feature_image[pos] = bit_value(bit_kind(pos[4:0]), pos[4:0], boot_compact, exc_set);
      end
    end
  endfunction

  // ********************************************
  // writable bits
  // ********************************************
  function is_writable;
    input [4:0] pos;
    begin
      is_writable = (bit_kind(pos) == KIND_EXC);
    end
  endfunction

  // ********************************************
  // state
  // ********************************************
  reg     [31:0] feature_word_reg;
  reg     [31:0] feature_word_next;
  reg     [31:0] rdata_next;
  wire           sel_hit;
  wire           read_hit;
  wire           write_hit;
  wire           boot_compact;
  wire    [31:0] reset_image;
  integer        wpos;

  // ********************************************
  // decode
  // ********************************************
  assign sel_hit   = addr_match(cp0_reg_num, cp0_reg_sel);
  assign read_hit  = cp0_read & sel_hit;
  assign write_hit = cp0_write & sel_hit;

  // ********************************************
  // hit output
  // ********************************************
  assign cp0_hit   = read_hit | write_hit;

  // ********************************************
  // power-on image
  // ********************************************
  assign boot_compact            = device_config_word0[`CFC_BOOT_CFG_BIT];
  assign reset_image             = feature_image(boot_compact, boot_compact);
  assign exception_entry_set_bit = feature_word_reg[`CFC_EXC_SET_BIT];

  // ********************************************
  // write path
  // ********************************************
  // only the exception-entry bit takes write data
  always @* begin
    feature_word_next = feature_word_reg;
    for (wpos = 0; wpos < `CFC_WORD_BITS; wpos = wpos + 1) begin
      if (write_hit && is_writable(wpos[4:0])) begin
        feature_word_next[wpos] = cp0_wdata[wpos];
      end else begin
        feature_word_next[wpos] = feature_word_reg[wpos];
      end
    end
  end

  // ********************************************
  // register update
  // ********************************************
  // boot choice reloaded on every reset cycle
  always @(posedge clk) begin
    if (reset) begin
      feature_word_reg <= reset_image;
    end else begin
      feature_word_reg <= feature_word_next;
    end
  end

  // ********************************************
  // read path
  // ********************************************
  always @* begin
    rdata_next = ZERO_WORD;
    case (read_hit)
      1'b1: begin
        rdata_next = feature_word_reg;
      end
      default: begin
        rdata_next = ZERO_WORD;
      end
    endcase
  end

  // ********************************************
  // read data register
  // ********************************************
  always @(posedge clk) begin
    if (reset) begin
      cp0_rdata <= ZERO_WORD;
    end else begin
      cp0_rdata <= rdata_next;
    end
  end

endmodule

// >>> verif/cfc_asserts.sv
`timescale 1ns/1ps
module cfc_asserts(input wire logic clk, reset, cp0_read, cp0_write, cp0_hit, exception_entry_set_bit,
  input wire logic [4:0] cp0_reg_num, input wire logic [2:0] cp0_reg_sel,
  input wire logic [31:0] device_config_word0, cp0_wdata, cp0_rdata);
  logic boot_q;
  wire  rh = cp0_read && cp0_hit;
  always @(posedge clk) if (reset) boot_q <= device_config_word0[6];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  hit_decode_a: assert property
    (cp0_hit == ((cp0_read || cp0_write) && cp0_reg_num == 5'h10 && cp0_reg_sel == 3'h3)) else $error("hit");
  fixed_image_a: assert property
    ($past(rh) |-> (cp0_rdata & 32'hfffe3fff) == 32'h80223d68) else $error("image");
  idle_zero_a: assert property (!$past(rh) |-> cp0_rdata == 32'h0) else $error("idle");
  exc_read_a: assert property
    ($past(rh) |-> cp0_rdata[16] == $past(exception_entry_set_bit)) else $error("bit16");
  exc_write_a: assert property
    (cp0_write && cp0_hit |=> exception_entry_set_bit == $past(cp0_wdata[16])) else $error("write");
  exc_hold_a: assert property (!(cp0_write && cp0_hit) |=> $stable(exception_entry_set_bit)) else $error("hold");
  boot_field_a: assert property ($past(rh) |-> cp0_rdata[15:14] == {1'b1, boot_q}) else $error("boot");
  reset_load_a: assert property ($fell(reset) |-> exception_entry_set_bit == boot_q) else $error("load");
endmodule

// >>> verif/cp0_master.sv
`timescale 1ns/1ps
module cp0_master(input wire clk, input wire [31:0] rdata, output reg rd, wr, output reg [4:0] num,
  output reg [2:0] sel, output reg [31:0] wd);
  initial {rd, wr, num, sel, wd} = 0;
  task acc(input r, w, input [4:0] n, input [2:0] s, input [31:0] d, output [31:0] q);
    @(posedge clk) #1;
    {rd, wr, num, sel, wd} = {r, w, n, s, d};
    @(posedge clk) #1;
    q = rdata;
    {rd, wr, wd} = {2'b0, ~d};
  endtask
endmodule

// >>> verif/core_feature_config_register_test.sv
`timescale 1ns/1ps
module core_feature_config_register_test;
  reg         clk = 0, reset = 1;
  reg  [31:0] cfg = 0, q;
  wire        rd, wr, hit, eb;
  wire [4:0]  num;
  wire [2:0]  sel;
  wire [31:0] wd, rdata;
  integer     error_cnt = 0, n_tests = 0, cyc = 0;
  reg         hit_seen = 0;
  always @(posedge clk) if (rd || wr) hit_seen <= hit;
  always #5 clk = ~clk;
  always @(posedge clk) if (++cyc == 400) begin error_cnt++; summarize; end
  cp0_master cp0_master_i(.clk(clk), .rdata(rdata), .rd(rd), .wr(wr), .num(num), .sel(sel), .wd(wd));
  core_feature_config_register core_feature_config_register_i(.clk(clk), .reset(reset),
    .device_config_word0(cfg), .cp0_read(rd), .cp0_write(wr), .cp0_reg_num(num), .cp0_reg_sel(sel),
    .cp0_wdata(wd), .cp0_rdata(rdata), .cp0_hit(hit), .exception_entry_set_bit(eb));
  task chk(input string nm, input [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin error_cnt++; $display("BAD %s exp %h seen %h", nm, exp, seen); end
  endtask
  task rst(input b);
    cfg[6] = b;
    reset = 1;
    repeat (12) @(posedge clk);
    #1 reset = 0;
  endtask
  task acc(input r, w, input [4:0] n, input [2:0] s, input [31:0] d);
    cp0_master_i.acc(r, w, n, s, d, q);
  endtask
  task summarize;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst(1);
    acc(1, 0, 5'h10, 3'h3, 0); chk("image", q, 32'h8023fd68);
    chk("hit", hit_seen, 1);
    acc(0, 1, 5'h10, 3'h3, 32'hfffeffff); chk("bit16", eb, 0);
    acc(1, 0, 5'h10, 3'h3, 0); chk("image", q, 32'h8022fd68);
    acc(0, 1, 5'h10, 3'h2, 32'h10000); chk("bit16", eb, 0);
    acc(1, 0, 5'h11, 3'h3, 0); chk("miss", q, 0);
    chk("nohit", hit_seen, 0);
    rst(0);
    acc(1, 0, 5'h10, 3'h3, 0); chk("image", q, 32'h8022bd68);
    acc(0, 1, 5'h10, 3'h3, 32'h10000); chk("bit16", eb, 1);
    acc(1, 0, 5'h10, 3'h3, 0); chk("image", q, 32'h8023bd68);
    summarize;
  end
endmodule
bind core_feature_config_register cfc_asserts cfc_asserts_i(.clk(clk), .reset(reset), .cp0_read(cp0_read),
  .cp0_write(cp0_write), .cp0_hit(cp0_hit), .exception_entry_set_bit(exception_entry_set_bit),
  .cp0_reg_num(cp0_reg_num), .cp0_reg_sel(cp0_reg_sel), .device_config_word0(device_config_word0),
  .cp0_wdata(cp0_wdata), .cp0_rdata(cp0_rdata));
